// [verilog/wake_event_indirect_regs.sv]
// Wake-event register bank reached through an indirect byte access scheme.
// Summary of operation
// - Function select 100 in control 0 bits 7:5 routes indirect access to wake registers.
// - Control 0 bits 3:0 pick the port; values 1 to 3 are ports one to three.
// - Control 1 holds an eight-bit byte offset into the indirect register.
// - Status offsets 0 to 3 map MSB byte down to LSB byte.
// - Mask offsets 4 to 7 map MSB byte down to LSB byte.
// - Indirect data register reads and writes the selected byte.
// - Status bit 2 sets on magic packet, write one clears it.
// - Status bit 1 sets on link-up, write one clears, resets zero.
// - Status bit 0 sets on energy, write one clears, resets zero.
// - Polarity zero, the reset value, makes the wake output active low.
// - Polarity one makes it active high; cleared enable keeps the output inactive.
// - Each mask bit lets its event assert the wake output.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module wake_event_indirect_regs #(
	parameter int NUM_PORTS = 3
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Event detectors, one entry per port.
	input wire wake_event_pkg::event_in_t [NUM_PORTS-1:0] events_i,
	// Wake output pin and interrupt.
	output logic power_wake_event_o,
	output logic irq_o
);
	import wake_event_pkg::*;

	// Elaboration check: only ports one to three are addressable, and interrupt bits share one byte.
	if (NUM_PORTS < 1 || NUM_PORTS > int'(PORT_LAST)) begin : g_bad_ports
		$error("NUM_PORTS must be between 1 and 3.");
	end

	// Bank state: indirect controls, global control, interrupt regs, output pin.
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [1:0] gbl;
		logic [NUM_PORTS-1:0] irq_status;
		logic [NUM_PORTS-1:0] irq_enable;
		logic [7:0] rdata;
		logic pin;
	} bank_state_t;

	bank_state_t state_reg;
	bank_state_t state_next;

	logic [NUM_PORTS-1:0][2:0] status;
	logic [NUM_PORTS-1:0][2:0] mask;
	logic [NUM_PORTS-1:0][2:0] status_clr;
	logic [NUM_PORTS-1:0] mask_wr;
	logic [NUM_PORTS-1:0] port_event;
	logic sel_wake;
	logic sel_port_ok;
	logic [3:0] port_idx;
	logic [31:0] status_word;
	logic [31:0] mask_word;
	logic [1:0] byte_sel;
	logic is_status_ofs;
	logic is_mask_ofs;
	logic [7:0] sel_byte;
	logic data_wr;
	logic wake_active;

	// Decode of the indirect selection.
	always_comb begin
		sel_wake = state_reg.ctrl0[FUNC_SEL_MSB:FUNC_SEL_LSB] == FUNC_WAKE_EVENT;
		port_idx = state_reg.ctrl0[PORT_SEL_MSB:PORT_SEL_LSB];
		sel_port_ok = port_idx >= PORT_FIRST && port_idx <= PORT_LAST && port_idx <= 4'(NUM_PORTS);
		is_status_ofs = state_reg.ctrl1 <= OFS_STATUS_LSB;
		is_mask_ofs = state_reg.ctrl1 >= OFS_MASK_MSB && state_reg.ctrl1 <= OFS_MASK_LSB;
		byte_sel = state_reg.ctrl1[1:0];
		data_wr = wr_i && addr_i == ADDR_IND_DATA && sel_wake && sel_port_ok;
	end

	// Selected port words and the byte chosen by the offset.
	always_comb begin
		status_word = '0;
		mask_word = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (port_idx == 4'(p + 1)) begin
				status_word = {29'h0, status[p]};
				mask_word = {29'h0, mask[p]};
			end
		end
		sel_byte = 8'h00;
		if (is_status_ofs) begin
			sel_byte = status_word[8'(3 - byte_sel) * 8 +: 8];
		end else if (is_mask_ofs) begin
			sel_byte = mask_word[8'(3 - byte_sel) * 8 +: 8];
		end
	end

	// Write strobes into the port registers; only the low byte carries event bits.
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			status_clr[p] = 3'h0;
			mask_wr[p] = 1'b0;
			if (data_wr && port_idx == 4'(p + 1) && byte_sel == 2'h3) begin
				status_clr[p] = is_status_ofs ? wdata_i[2:0] : 3'h0;
				mask_wr[p] = is_mask_ofs;
			end
		end
	end

	// One register pair per port.
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		wake_port_regs u_port (
			.clk_i(clk_i),
			.resetn_i(resetn_i),
			.event_i(events_i[p]),
			.status_clr_i(status_clr[p]),
			.mask_wr_i(mask_wr[p]),
			.mask_wdata_i(wdata_i[2:0]),
			.status_o(status[p]),
			.mask_o(mask[p])
		);
		assign port_event[p] = |(status[p] & mask[p]);
	end

	// Wake condition from all ports.
	always_comb begin
		wake_active = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			wake_active = wake_active | port_event[p];
		end
	end

	// Register port, interrupt flags and output pin next state.
	always_comb begin
		state_next = state_reg;
		if (wr_i) begin
			if (addr_i == ADDR_IND_CTRL0) begin
				state_next.ctrl0 = wdata_i;
			end else if (addr_i == ADDR_IND_CTRL1) begin
				state_next.ctrl1 = wdata_i;
			end else if (addr_i == ADDR_GLOBAL_CTRL) begin
				state_next.gbl = wdata_i[1:0];
			end else if (addr_i == ADDR_IRQ_CLEAR) begin
				state_next.irq_status = state_reg.irq_status & ~wdata_i[NUM_PORTS-1:0];
			end else if (addr_i == ADDR_IRQ_ENABLE) begin
				state_next.irq_enable = wdata_i[NUM_PORTS-1:0];
			end
		end
		// Set of a port's interrupt flag wins over a clear.
		state_next.irq_status = state_next.irq_status | port_event;
		state_next.rdata = 8'h00;
		if (rd_i) begin
			if (addr_i == ADDR_IND_CTRL0) begin
				state_next.rdata = state_reg.ctrl0;
			end else if (addr_i == ADDR_IND_CTRL1) begin
				state_next.rdata = state_reg.ctrl1;
			end else if (addr_i == ADDR_IND_DATA) begin
				state_next.rdata = (sel_wake && sel_port_ok) ? sel_byte : 8'h00;
			end else if (addr_i == ADDR_GLOBAL_CTRL) begin
				state_next.rdata = {6'h0, state_reg.gbl};
			end else if (addr_i == ADDR_IRQ_STATUS) begin
				state_next.rdata = 8'(state_reg.irq_status);
			end else if (addr_i == ADDR_IRQ_ENABLE) begin
				state_next.rdata = 8'(state_reg.irq_enable);
			end
		end
		// Pin level: asserted level follows polarity, idle is the opposite.
		if (state_reg.gbl[GBL_ENABLE] && wake_active) begin
			state_next.pin = state_reg.gbl[GBL_POLARITY];
		end else begin
			state_next.pin = ~state_reg.gbl[GBL_POLARITY];
		end
	end

	// State register; pin idles high because polarity resets to active low.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= '{ctrl0: IND_CTRL_RESET, ctrl1: IND_CTRL_RESET, gbl: GLOBAL_RESET,
				irq_status: '0, irq_enable: '0, rdata: 8'h00, pin: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_o = state_reg.rdata;
	assign power_wake_event_o = state_reg.pin;
	assign irq_o = |(state_reg.irq_status & state_reg.irq_enable);
endmodule // wake_event_indirect_regs

// [verilog/wake_event_pkg.sv]
// Package with register offsets, field positions, reset values and carrier types of the wake-event register bank.
package wake_event_pkg;

	// Direct register addresses on the plain register port.
	localparam logic [7:0] ADDR_IND_CTRL0 = 8'h6e;
	localparam logic [7:0] ADDR_IND_CTRL1 = 8'h6f;
	localparam logic [7:0] ADDR_IND_DATA = 8'ha0;
	localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h70;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h71;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h72;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h73;

	// Indirect control 0 fields.
	localparam int FUNC_SEL_MSB = 7;
	localparam int FUNC_SEL_LSB = 5;
	localparam logic [2:0] FUNC_WAKE_EVENT = 3'h4;
	localparam int PORT_SEL_MSB = 3;
	localparam int PORT_SEL_LSB = 0;
	localparam logic [3:0] PORT_GLOBAL = 4'h0;
	localparam logic [3:0] PORT_FIRST = 4'h1;
	localparam logic [3:0] PORT_LAST = 4'h3;

	// Indirect byte offsets.
	localparam logic [7:0] OFS_STATUS_MSB = 8'h00;
	localparam logic [7:0] OFS_STATUS_LSB = 8'h03;
	localparam logic [7:0] OFS_MASK_MSB = 8'h04;
	localparam logic [7:0] OFS_MASK_LSB = 8'h07;

	// Event bit positions, shared by status and mask.
	localparam int EV_ENERGY = 0;
	localparam int EV_LINK_UP = 1;
	localparam int EV_MAGIC = 2;
	localparam int NUM_EVENTS = 3;

	// Global control fields: polarity and enable.
	localparam int GBL_POLARITY = 0;
	localparam int GBL_ENABLE = 1;

	// Reset values.
	localparam logic [7:0] IND_CTRL_RESET = 8'h00;
	localparam logic [2:0] EVENT_RESET = 3'h0;
	localparam logic [1:0] GLOBAL_RESET = 2'h0;

	// Plain register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// Per-port detected event pulses.
	typedef struct packed {
		logic magic;
		logic link_up;
		logic energy;
	} event_in_t;

endpackage

// [verilog/wake_port_regs.sv]
// Per-port sticky wake-event status and mask register pair.
`timescale 1ns/1ps
module wake_port_regs (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Detected events of this port.
	input wire wake_event_pkg::event_in_t event_i,
	// Software write-one-to-clear and mask write.
	input wire logic [2:0] status_clr_i,
	input wire logic mask_wr_i,
	input wire logic [2:0] mask_wdata_i,
	// Register contents.
	output logic [2:0] status_o,
	output logic [2:0] mask_o
);
	import wake_event_pkg::*;

	typedef struct packed {
		logic [2:0] status;
		logic [2:0] mask;
	} port_state_t;

	port_state_t state_reg;
	port_state_t state_next;
	logic [2:0] ev;

	// Set wins over a clear in the same cycle.
	always_comb begin
		ev = '0;
		ev[EV_MAGIC] = event_i.magic;
		ev[EV_LINK_UP] = event_i.link_up;
		ev[EV_ENERGY] = event_i.energy;
		state_next = state_reg;
		state_next.status = (state_reg.status & ~status_clr_i) | ev;
		if (mask_wr_i) begin
			state_next.mask = mask_wdata_i;
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= '{status: EVENT_RESET, mask: EVENT_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign status_o = state_reg.status;
	assign mask_o = state_reg.mask;
endmodule // wake_port_regs

// [tb/wake_event_indirect_regs_props.sv]
// Checker of the wake-event register bank behaviour at its ports.
`timescale 1ns/1ps
module wake_event_indirect_regs_props import wake_event_pkg::*; #(
	parameter int NUM_PORTS = 3
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Events and outputs.
	input wire wake_event_pkg::event_in_t [NUM_PORTS-1:0] events_i,
	input wire logic power_wake_event_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Register accesses that the properties start from.
	sequence s_rd(a);
		rd_i && addr_i == a;
	endsequence
	sequence s_gbl_off;
		wr_i && addr_i == ADDR_GLOBAL_CTRL && !wdata_i[GBL_ENABLE] ##1 !(wr_i && addr_i == ADDR_GLOBAL_CTRL);
	endsequence
	// Read data only in the slot after a read.
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data outside slot");
	a_unmapped_read: assert property (s_rd(8'h00) |=> rdata_o == 8'h00) else $error("unmapped read");
	a_ctrl0_back: assert property (wr_i && addr_i == ADDR_IND_CTRL0 ##1 s_rd(ADDR_IND_CTRL0)
		|=> rdata_o == $past(wdata_i, 2)) else $error("control 0 readback");
	a_ctrl1_back: assert property (wr_i && addr_i == ADDR_IND_CTRL1 ##1 s_rd(ADDR_IND_CTRL1)
		|=> rdata_o == $past(wdata_i, 2)) else $error("control 1 readback");
	a_func_gate: assert property (wr_i && addr_i == ADDR_IND_CTRL0 && wdata_i[7:5] != FUNC_WAKE_EVENT
		##1 s_rd(ADDR_IND_DATA) |=> rdata_o == 8'h00) else $error("foreign function read");
	a_offset_gate: assert property (wr_i && addr_i == ADDR_IND_CTRL1 && wdata_i[1:0] != 2'h3
		##1 s_rd(ADDR_IND_DATA) |=> rdata_o == 8'h00) else $error("upper byte read");
	a_pin_off: assert property (s_gbl_off |=> power_wake_event_o == !$past(wdata_i[GBL_POLARITY], 2))
		else $error("disabled pin active");
	a_irq_off: assert property (wr_i && addr_i == ADDR_IRQ_ENABLE && wdata_i == 8'h00 |=> !irq_o)
		else $error("masked interrupt high");
endmodule // wake_event_indirect_regs_props

bind wake_event_indirect_regs wake_event_indirect_regs_props #(.NUM_PORTS(NUM_PORTS)) u_props (.clk_i(clk_i),
	.resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.events_i(events_i), .power_wake_event_o(power_wake_event_o), .irq_o(irq_o));

// [tb/wake_event_indirect_regs_tb_top.sv]
// Self-checking testbench of the wake-event register bank.
`timescale 1ns/1ps
module wake_event_indirect_regs_tb_top;
	import wake_event_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	event_in_t [2:0] events_i = '0;
	logic power_wake_event_o;
	logic irq_o;
	logic rd_d = 1'b0;
	logic [7:0] expq[$];
	int miscompares = 0;
	int checks_done = 0;
	int p;
	int e;
	logic [31:0] r;
	// Device with three ports.
	wake_event_indirect_regs #(.NUM_PORTS(3)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .events_i(events_i),
		.power_wake_event_o(power_wake_event_o), .irq_o(irq_o));
	// Clock of 5 ns period.
	always #2.5 clk_i = ~clk_i;
	// Count and report one comparison.
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// One-cycle register read; the expected byte is queued for the monitor.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		expq.push_back(exp);
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	// Write followed at once by a read, with no idle cycle between the strobes.
	task automatic wrrd(input logic [7:0] wa, input logic [7:0] d, input logic [7:0] ra, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= wa;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		addr_i <= ra;
		expq.push_back(exp);
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	// Select port and byte offset of the wake registers.
	task automatic sel(input logic [3:0] pn, input logic [7:0] o);
		wr(ADDR_IND_CTRL0, {FUNC_WAKE_EVENT, 1'b0, pn});
		wr(ADDR_IND_CTRL1, o);
	endtask
	// Wait for the registered pin, then compare pin and interrupt.
	task automatic pins(input logic pin, input logic irq);
		repeat (3) @(posedge clk_i);
		#1;
		cmp({7'h00, power_wake_event_o}, {7'h00, pin});
		cmp({7'h00, irq_o}, {7'h00, irq});
	endtask
	// Print counts and verdict, then end the run.
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Monitor takes the oldest note whenever read data appear.
	always @(posedge clk_i) rd_d <= rd_i;
	always @(negedge clk_i) begin
		if (rd_d && expq.size() > 0) cmp(rdata_o, expq.pop_front());
	end
	// Watchdog: the tests need well under 1000 cycles, so 4000 cycles means a hang.
	initial begin
		repeat (4000) @(posedge clk_i);
		miscompares++;
		stop_test;
	end
	// Main sequence.
	initial begin
		r = $urandom(32'h1731);
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		pins(1'b1, 1'b0);
		rd(ADDR_GLOBAL_CTRL, 8'h00);
		rd(8'h00, 8'h00);
		r = $urandom;
		wr(ADDR_IND_CTRL1, r[7:0]);
		rd(ADDR_IND_CTRL1, r[7:0]);
		$display("test reset done");
		for (p = 0; p < 3; p++) begin
			for (e = 0; e < 3; e++) begin
				sel(p[3:0] + 4'h1, OFS_STATUS_LSB);
				rd(ADDR_IND_DATA, 8'h00);
				@(posedge clk_i);
				events_i[p][e] <= 1'b1;
				@(posedge clk_i);
				events_i[p][e] <= 1'b0;
				rd(ADDR_IND_DATA, 8'h01 << e);
				wr(ADDR_IND_CTRL1, OFS_STATUS_MSB);
				rd(ADDR_IND_DATA, 8'h00);
				wr(ADDR_IND_CTRL1, OFS_STATUS_LSB);
				wr(ADDR_IND_DATA, 8'h07);
				rd(ADDR_IND_DATA, 8'h00);
				wr(ADDR_IND_CTRL1, OFS_MASK_LSB);
				wr(ADDR_IND_DATA, 8'h01 << e);
				rd(ADDR_IND_DATA, 8'h01 << e);
				wr(ADDR_IND_CTRL1, OFS_MASK_MSB);
				wr(ADDR_IND_DATA, 8'hff);
				rd(ADDR_IND_DATA, 8'h00);
			end
		end
		$display("test status and mask done");
		@(posedge clk_i);
		events_i[0].magic <= 1'b1;
		@(posedge clk_i);
		events_i[0].magic <= 1'b0;
		wr(ADDR_IND_CTRL0, 8'h01);
		wr(ADDR_IND_CTRL1, OFS_STATUS_LSB);
		rd(ADDR_IND_DATA, 8'h00);
		for (p = 0; p < 5; p += 4) begin
			sel(p[3:0], OFS_STATUS_LSB);
			rd(ADDR_IND_DATA, 8'h00);
		end
		$display("test selection done");
		wrrd(ADDR_IND_CTRL0, 8'h25, ADDR_IND_CTRL0, 8'h25);
		wrrd(ADDR_IND_CTRL0, 8'h21, ADDR_IND_DATA, 8'h00);
		wrrd(ADDR_IND_CTRL1, 8'h06, ADDR_IND_CTRL1, 8'h06);
		wr(ADDR_IND_CTRL0, 8'h81);
		wrrd(ADDR_IND_CTRL1, OFS_STATUS_MSB, ADDR_IND_DATA, 8'h00);
		wrrd(ADDR_IND_CTRL1, OFS_STATUS_LSB, ADDR_IND_DATA, 8'h04);
		rd(ADDR_IRQ_STATUS, 8'h01);
		// A magic event in the same cycle as its clear keeps the bit set.
		@(posedge clk_i);
		addr_i <= ADDR_IND_DATA;
		wdata_i <= 8'h04;
		wr_i <= 1'b1;
		events_i[0].magic <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		events_i[0].magic <= 1'b0;
		rd(ADDR_IND_DATA, 8'h04);
		$display("test back to back done");
		wr(ADDR_GLOBAL_CTRL, 8'h02);
		pins(1'b0, 1'b0);
		wr(ADDR_GLOBAL_CTRL, 8'h03);
		wr(ADDR_IRQ_ENABLE, 8'h01);
		pins(1'b1, 1'b1);
		rd(ADDR_IRQ_ENABLE, 8'h01);
		rd(ADDR_GLOBAL_CTRL, 8'h03);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		pins(1'b1, 1'b1);
		sel(4'h1, OFS_MASK_LSB);
		wr(ADDR_IND_DATA, 8'h00);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		pins(1'b0, 1'b0);
		wr(ADDR_IND_DATA, 8'h04);
		wr(ADDR_GLOBAL_CTRL, 8'h01);
		wr(ADDR_IRQ_ENABLE, 8'h00);
		pins(1'b0, 1'b0);
		$display("test wake pin done");
		repeat (2) @(posedge clk_i);
		stop_test;
	end
endmodule // wake_event_indirect_regs_tb_top
